//--- rtl/ext_area_sel_pkg.sv
// constants for the external area interface select registers
// assumes a 32-bit ahb-lite register bus, one word per register
package ext_area_sel_pkg;
  localparam int          NUM_AREAS          = 8;
  localparam int          ADDR_W             = 4;
  // byte addresses (offsets chosen for this block)
  localparam logic [3:0]  OFF_BYTE_CTRL_SEL  = 4'h0;
  localparam logic [3:0]  OFF_BURST_ROM_CFG  = 4'h4;
  localparam logic [3:0]  OFF_AREA_8BIT      = 4'h8;
  // byte-control register fields
  localparam int          BCSEL_LSB          = 8;
  localparam logic [15:0] BYTE_CTRL_WMASK    = 16'hff00;
  // burst rom register fields
  localparam int          A0_ROM_BIT         = 15;
  localparam int          A0_CYC_LSB         = 12;
  localparam int          A0_WORDS_LSB       = 8;
  localparam int          A1_ROM_BIT         = 7;
  localparam int          A1_CYC_LSB         = 4;
  localparam int          A1_WORDS_LSB       = 0;
  localparam logic [15:0] BURST_ROM_WMASK    = 16'hf3f3;
  localparam logic [7:0]  AREA_8BIT_WMASK    = 8'hff;
  // reset values
  localparam logic [15:0] BYTE_CTRL_RESET    = 16'h0000;
  localparam logic [15:0] BURST_ROM_RESET    = 16'h0000;
  localparam logic [7:0]  AREA_8BIT_RESET    = 8'h00;
  localparam logic [3:0]  CYCLES_RESET       = 4'h1;
  localparam logic [5:0]  WORDS_RESET        = 6'h04;
  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ         = 2'b11;
endpackage

//--- rtl/burst_field_decode.sv
// decodes one area's burst rom fields into cycle and word limits
// assumes fields come straight from the configuration register
`timescale 1ns/1ns
module burst_field_decode (
  input  wire logic [2:0] cyc_code,
  input  wire logic [1:0] words_code,
  output logic      [3:0] cycles,
  output logic      [5:0] max_words
);
  always_comb begin
    cycles = {1'b0, cyc_code} + 4'h1;
    case (words_code)
      2'b00:   max_words = 6'h04;
      2'b01:   max_words = 6'h08;
      2'b10:   max_words = 6'h10;
      default: max_words = 6'h20;
    endcase
  end
endmodule // burst_field_decode

//--- rtl/ext_area_interface_select_regs.sv
// external area interface select register pair with ahb-lite slave
// assumes one ahb-lite master; area width flags written by software
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
// Overview of operation
// - per-area select bit: 0 basic interface, 1 byte-control sram interface
// - areas marked 8-bit never run as byte-control sram
// - reserved bits read zero and ignore writes
// - bit 15 makes area 0 a burst rom interface
// - bit 7 makes area 1 a burst rom interface
// - bits 14..12 give area 0 burst cycles k plus one
// - bits 6..4 give area 1 burst cycles k plus one
// - bits 9..8 limit area 0 bursts to 4,8,16,32 words
// - bits 1..0 limit area 1 bursts to 4,8,16,32 words
// - all fields reset to zero
module ext_area_interface_select_regs
  import ext_area_sel_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [ext_area_sel_pkg::NUM_AREAS-1:0] byte_ctrl_sram_active,
  output logic                         burst_rom_en_area0,
  output logic                         burst_rom_en_area1,
  output logic      [3:0]              burst_cycles_area0,
  output logic      [3:0]              burst_cycles_area1,
  output logic      [5:0]              burst_max_words_area0,
  output logic      [5:0]              burst_max_words_area1
);
  import ext_area_sel_pkg::*;

  // bus phase, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_WDATA = 2'b10
  } bus_state_t;

  // bus slave state
  bus_state_t           bus_state_reg;
  bus_state_t           bus_state_next;
  logic [ADDR_W-1:0]    wr_addr_reg;
  logic [ADDR_W-1:0]    wr_addr_next;
  logic                 hreadyout_reg;
  logic                 hreadyout_next;
  logic                 hresp_reg;
  logic                 hresp_next;
  logic [31:0]          hrdata_reg;
  logic [31:0]          hrdata_next;

  // configuration registers
  logic [15:0]          byte_ctrl_reg;
  logic [15:0]          byte_ctrl_next;
  logic [15:0]          burst_rom_reg;
  logic [15:0]          burst_rom_next;
  logic [7:0]           area_8bit_reg;
  logic [7:0]           area_8bit_next;

  // output registers
  logic [NUM_AREAS-1:0] bc_act_reg;
  logic [NUM_AREAS-1:0] bc_act_next;
  logic                 rom0_reg;
  logic                 rom0_next;
  logic [3:0]           cyc0_reg;
  logic [3:0]           cyc0_next;
  logic [5:0]           words0_reg;
  logic [5:0]           words0_next;
  logic                 rom1_reg;
  logic                 rom1_next;
  logic [3:0]           cyc1_reg;
  logic [3:0]           cyc1_next;
  logic [5:0]           words1_reg;
  logic [5:0]           words1_next;

  // decode and strobe wires
  logic [3:0]           cyc0_dec;
  logic [3:0]           cyc1_dec;
  logic [5:0]           words0_dec;
  logic [5:0]           words1_dec;
  logic                 access;
  logic                 wr_data_phase;
  logic                 wr_byte_ctrl;
  logic                 wr_burst_rom;
  logic                 wr_area_8bit;
  logic [ADDR_W-1:0]    rd_addr;

  // refuse constants the register layout cannot serve
  if (NUM_AREAS > 8 || BCSEL_LSB + NUM_AREAS > 16) begin : g_sel_fit_chk
    $error("area select field does not fit the register");
  end
  if (ADDR_W < 4) begin : g_addr_w_chk
    $error("offset decode needs four address bits");
  end
  if (A0_CYC_LSB + 3 > 16 || A1_CYC_LSB + 3 > A0_WORDS_LSB) begin : g_field_chk
    $error("burst rom fields overlap or overflow");
  end

  assign access        = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rd_addr       = haddr[ADDR_W-1:0];
  assign wr_data_phase = (bus_state_reg == BUS_WDATA);

  // bus slave: zero wait states, always okay, write data taken in data phase
  always_comb begin
    bus_state_next = BUS_IDLE;
    wr_addr_next   = wr_addr_reg;
    hreadyout_next = 1'b1;
    hresp_next     = 1'b0;
    if (access) begin
      wr_addr_next = rd_addr;
    end
    case (bus_state_reg)
      BUS_IDLE: begin
        if (access && hwrite) begin
          bus_state_next = BUS_WDATA;
        end
      end
      BUS_WDATA: begin
        // a new write may start in the data phase of the last one
        if (access && hwrite) begin
          bus_state_next = BUS_WDATA;
        end
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_state_reg <= BUS_IDLE;
      wr_addr_reg   <= '0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      wr_addr_reg   <= wr_addr_next;
      hreadyout_reg <= hreadyout_next;
      hresp_reg     <= hresp_next;
    end
  end

  // write strobes, one per register, in the data phase
  always_comb begin
    wr_byte_ctrl = 1'b0;
    wr_burst_rom = 1'b0;
    wr_area_8bit = 1'b0;
    if (wr_data_phase) begin
      case (wr_addr_reg)
        OFF_BYTE_CTRL_SEL: wr_byte_ctrl = 1'b1;
        OFF_BURST_ROM_CFG: wr_burst_rom = 1'b1;
        OFF_AREA_8BIT:     wr_area_8bit = 1'b1;
        default: ;
      endcase
    end
  end

  // byte-control select register, low byte reserved
  always_comb begin
    byte_ctrl_next = byte_ctrl_reg;
    if (wr_byte_ctrl) begin
      byte_ctrl_next = hwdata[15:0] & BYTE_CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      byte_ctrl_reg <= BYTE_CTRL_RESET;
    end else begin
      byte_ctrl_reg <= byte_ctrl_next;
    end
  end

  // burst rom register, bits 11, 10, 3 and 2 reserved
  always_comb begin
    burst_rom_next = burst_rom_reg;
    if (wr_burst_rom) begin
      burst_rom_next = hwdata[15:0] & BURST_ROM_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_rom_reg <= BURST_ROM_RESET;
    end else begin
      burst_rom_reg <= burst_rom_next;
    end
  end

  // 8-bit area flags, stand-in for the width register
  always_comb begin
    area_8bit_next = area_8bit_reg;
    if (wr_area_8bit) begin
      area_8bit_next = hwdata[7:0] & AREA_8BIT_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      area_8bit_reg <= AREA_8BIT_RESET;
    end else begin
      area_8bit_reg <= area_8bit_next;
    end
  end

  // read mux sees a pending write, so read after write is current
  always_comb begin
    hrdata_next = hrdata_reg;
    if (access && !hwrite) begin
      case (rd_addr)
        OFF_BYTE_CTRL_SEL: hrdata_next = {16'h0000, byte_ctrl_next};
        OFF_BURST_ROM_CFG: hrdata_next = {16'h0000, burst_rom_next};
        OFF_AREA_8BIT:     hrdata_next = {24'h000000, area_8bit_next};
        default:           hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  // per-area selection: 8-bit areas never run byte-control sram
  for (genvar g = 0; g < NUM_AREAS; g++) begin : g_area
    assign bc_act_next[g] = byte_ctrl_reg[BCSEL_LSB+g] & ~area_8bit_reg[g];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bc_act_reg <= '0;
    end else begin
      bc_act_reg <= bc_act_next;
    end
  end

  burst_field_decode u_dec0 (
    .cyc_code   (burst_rom_reg[A0_CYC_LSB +: 3]),
    .words_code (burst_rom_reg[A0_WORDS_LSB +: 2]),
    .cycles     (cyc0_dec),
    .max_words  (words0_dec)
  );

  burst_field_decode u_dec1 (
    .cyc_code   (burst_rom_reg[A1_CYC_LSB +: 3]),
    .words_code (burst_rom_reg[A1_WORDS_LSB +: 2]),
    .cycles     (cyc1_dec),
    .max_words  (words1_dec)
  );

  // area 0 burst rom outputs, one cycle behind the register
  always_comb begin
    rom0_next   = burst_rom_reg[A0_ROM_BIT];
    cyc0_next   = cyc0_dec;
    words0_next = words0_dec;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rom0_reg   <= 1'b0;
      cyc0_reg   <= CYCLES_RESET;
      words0_reg <= WORDS_RESET;
    end else begin
      rom0_reg   <= rom0_next;
      cyc0_reg   <= cyc0_next;
      words0_reg <= words0_next;
    end
  end

  // area 1 burst rom outputs, one cycle behind the register
  always_comb begin
    rom1_next   = burst_rom_reg[A1_ROM_BIT];
    cyc1_next   = cyc1_dec;
    words1_next = words1_dec;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rom1_reg   <= 1'b0;
      cyc1_reg   <= CYCLES_RESET;
      words1_reg <= WORDS_RESET;
    end else begin
      rom1_reg   <= rom1_next;
      cyc1_reg   <= cyc1_next;
      words1_reg <= words1_next;
    end
  end

  assign hrdata                = hrdata_reg;
  assign hreadyout             = hreadyout_reg;
  assign hresp                 = hresp_reg;
  assign byte_ctrl_sram_active = bc_act_reg;
  assign burst_rom_en_area0    = rom0_reg;
  assign burst_rom_en_area1    = rom1_reg;
  assign burst_cycles_area0    = cyc0_reg;
  assign burst_cycles_area1    = cyc1_reg;
  assign burst_max_words_area0 = words0_reg;
  assign burst_max_words_area1 = words1_reg;
endmodule // ext_area_interface_select_regs

//--- sim/ext_area_sel_checker.sv
// assertions for the area select register pair
// bound to the top module, sees its ports only
`timescale 1ns/1ns
module ext_area_sel_checker
  import ext_area_sel_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic        hwrite,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  byte_ctrl_sram_active,
  input wire logic        burst_rom_en_area0,
  input wire logic        burst_rom_en_area1,
  input wire logic [3:0]  burst_cycles_area0,
  input wire logic [3:0]  burst_cycles_area1,
  input wire logic [5:0]  burst_max_words_area0,
  input wire logic [5:0]  burst_max_words_area1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // write address phase, then its data phase
  sequence wr_s(logic [3:0] off);
    hsel && hready && htrans[1] && hwrite && haddr[3:0] == off ##1 1'b1;
  endsequence
  sequence rd_s(logic [3:0] off);
    hsel && hready && htrans[1] && !hwrite && haddr[3:0] == off;
  endsequence
  // outputs follow one edge after the data phase, so data is two edges back
  rom0_sel_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_rom_en_area0 == $past(hwdata[15], 2)) else $error("area0 rom select wrong");
  rom1_sel_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_rom_en_area1 == $past(hwdata[7], 2)) else $error("area1 rom select wrong");
  cyc0_val_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_cycles_area0 == {1'b0, $past(hwdata[14:12], 2)} + 4'h1) else $error("area0 cycles");
  cyc1_val_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_cycles_area1 == {1'b0, $past(hwdata[6:4], 2)} + 4'h1) else $error("area1 cycles");
  words0_val_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_max_words_area0 == (6'h04 << $past(hwdata[9:8], 2))) else $error("area0 words");
  words1_val_a: assert property (wr_s(OFF_BURST_ROM_CFG) |=> ##1
    burst_max_words_area1 == (6'h04 << $past(hwdata[1:0], 2))) else $error("area1 words");
  rsvd_rd_a: assert property (rd_s(OFF_BYTE_CTRL_SEL) |=>
    hrdata[7:0] == 8'h00) else $error("reserved bits not zero");
  sram_sel_a: assert property (wr_s(OFF_BYTE_CTRL_SEL) |=> ##1
    (byte_ctrl_sram_active & ~$past(hwdata[15:8], 2)) == 8'h00) else $error("unselected area");
  narrow_a: assert property (wr_s(OFF_AREA_8BIT) |=> ##1
    (byte_ctrl_sram_active & $past(hwdata[7:0], 2)) == 8'h00) else $error("8-bit area active");
endmodule // ext_area_sel_checker
bind ext_area_interface_select_regs ext_area_sel_checker checker_inst (.core_clk, .resetn,
  .hsel, .hready, .hwrite, .htrans, .haddr, .hwdata, .hrdata, .byte_ctrl_sram_active,
  .burst_rom_en_area0, .burst_rom_en_area1, .burst_cycles_area0, .burst_cycles_area1,
  .burst_max_words_area0,
  .burst_max_words_area1);

//--- sim/ext_area_interface_select_regs_tb.sv
// self-checking bench for the area select register pair
// drives the ahb-lite slave directly, hready looped from hreadyout
`timescale 1ns/1ns
module ext_area_interface_select_regs_tb;
  import ext_area_sel_pkg::*;
  logic        core_clk, resetn, hsel, hwrite, hreadyout, hresp, rom0, rom1;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  cyc0, cyc1;
  logic [5:0]  wd0, wd1;
  logic [7:0]  act;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          error_cnt = 0;
  int          tests_run = 0;
  ext_area_interface_select_regs ext_area_interface_select_regs_inst (.core_clk, .resetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .byte_ctrl_sram_active(act), .burst_rom_en_area0(rom0),
    .burst_rom_en_area1(rom1), .burst_cycles_area0(cyc0), .burst_cycles_area1(cyc1),
    .burst_max_words_area0(wd0), .burst_max_words_area1(wd1));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one single word transfer, read data left in q
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {28'h0, a}; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [31:0] outs();
    return {2'b00, rom0, rom1, act, cyc0, cyc1, wd0, wd1};
  endfunction
  task t_reset;
    chk(outs(), {2'b00, 2'b00, 8'h00, 4'h1, 4'h1, 6'h04, 6'h04});
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    xfer(1'b0, OFF_BURST_ROM_CFG, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, OFF_BYTE_CTRL_SEL, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_rom;
    logic [2:0]  k;
    logic [31:0] d;
    xfer(1'b1, OFF_BYTE_CTRL_SEL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      d = 32'hffff_0c0c | {16'h0, k[0], k, 2'b00, k[1:0], ~k[0], k, 2'b00, k[1:0]};
      xfer(1'b1, OFF_BURST_ROM_CFG, d);
      xfer(1'b0, OFF_BURST_ROM_CFG, 32'h0);
      chk(q, d & 32'h0000_f3f3);
      chk(outs(), {2'b00, k[0], ~k[0], 8'h00, {1'b0, k} + 4'h1, {1'b0, k} + 4'h1,
        6'h04 << k[1:0], 6'h04 << k[1:0]});
    end
  endtask
  task t_sram;
    xfer(1'b1, OFF_BURST_ROM_CFG, 32'h0);
    xfer(1'b1, OFF_AREA_8BIT, 32'h0000_000f);
    xfer(1'b1, OFF_BYTE_CTRL_SEL, 32'h0000_a5ff);
    xfer(1'b0, OFF_BYTE_CTRL_SEL, 32'h0);
    chk(q, 32'h0000_a500);
    chk({24'h0, act}, 32'h0000_00a0);
    xfer(1'b1, OFF_AREA_8BIT, 32'h0);
    xfer(1'b1, 4'hc, 32'hffff_ffff);
    xfer(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    chk({24'h0, act}, 32'h0000_00a5);
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_rom();
    t_sram();
    xfer(1'b1, OFF_BURST_ROM_CFG, 32'h0000_f3f3);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    stop_test();
  end
endmodule // ext_area_interface_select_regs_tb
